/* File: rtl/ocd_core.sv */
// Instruction cycle sequencer with state accounting
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defs.svh"
// Operation
// - Operation from first byte, bits 15..8
// - Bit 7 splits shared first-byte codes
// - Push/pop decode as data moves
// - Total states sum count times per-cycle states
// - Fetch, branch-address, stack: two states
// - Peripheral byte access: two or three states
// - Memory bit write: 2 fetch, 2 byte
// - Memory bit read: 2 fetch, 1 byte
// - Register bit op: one fetch only
module ocd_core (
  input  wire logic        mclk_i,      // System clock
  input  wire logic        rstn_i,      // Async reset, active low
  input  wire logic [15:0] word_i,      // First instruction word
  input  wire logic        start_i,     // Begin execution pulse
  input  wire logic        peri_i,      // Data access targets peripheral
  input  wire logic        peri_slow_i, // Peripheral needs three states
  output logic             busy_o,      // Instruction executing
  output logic             done_o,      // Instruction completed pulse
  output logic [2:0]       cyc_o,       // Current cycle type
  output logic             cyc_strobe_o,// Cycle start pulse
  output logic             write_o,     // Byte access is write phase
  output logic [3:0]       op_o,        // Decoded operation class
  output logic             variant_o,   // Split bit of decoded word
  output logic [3:0]       cond_o,      // Branch condition
  output logic [7:0]       states_o     // States of last instruction
);
  logic                   rst_q1;
  logic                   rst_q2;
  ocd_pkg::ocd_dec_t      dec;
  ocd_pkg::ocd_state_all_t s;
  ocd_pkg::ocd_state_all_t next_s;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  ocd_decode ocd_decode_i (
    .word_i (word_i),
    .dec_o  (dec)
  );

  function automatic logic [3:0] cyc_states(input ocd_pkg::ocd_cyc_t c, input logic p,
                                            input logic slow);
    case (c)
      ocd_pkg::OCD_CYC_INTERNAL: cyc_states = `OCD_ST_INTERNAL;
      ocd_pkg::OCD_CYC_BYTE:
        cyc_states = p ? (slow ? `OCD_ST_PERI_SLOW : `OCD_ST_PERI_FAST)
                       : `OCD_ST_MEM;
      default: cyc_states = `OCD_ST_MEM;
    endcase
  endfunction

  function automatic logic pick(input ocd_pkg::ocd_counts_t l, output ocd_pkg::ocd_cyc_t c);
    pick = 1'b1;
    if (l.fetch != 4'h0) c = ocd_pkg::OCD_CYC_FETCH;
    else if (l.braddr != 4'h0) c = ocd_pkg::OCD_CYC_BRADDR;
    else if (l.stack != 4'h0) c = ocd_pkg::OCD_CYC_STACK;
    else if (l.byte_acc != 4'h0) c = ocd_pkg::OCD_CYC_BYTE;
    else if (l.word_acc != 4'h0) c = ocd_pkg::OCD_CYC_WORD;
    else if (l.internal != 4'h0) c = ocd_pkg::OCD_CYC_INTERNAL;
    else begin
      c = ocd_pkg::OCD_CYC_FETCH;
      pick = 1'b0;
    end
  endfunction

  always_comb begin
    ocd_pkg::ocd_counts_t l;
    ocd_pkg::ocd_cyc_t    c;
    logic                 more;
    logic [3:0]           n;
    l = '0;
    c = ocd_pkg::OCD_CYC_FETCH;
    more = 1'b0;
    n = 4'h0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.cyc_strobe = 1'b0;
    case (s.state)
      ocd_pkg::OCD_IDLE: begin
        if (start_i) begin
          next_s.dec = dec;
          l = dec.counts;
          more = pick(l, c);
          next_s.cyc = c;
          next_s.sub = cyc_states(c, peri_i, peri_slow_i);
          next_s.left = l;
          next_s.total = 8'h0;
          next_s.busy = 1'b1;
          next_s.cyc_strobe = 1'b1;
          next_s.write_phase = 1'b0;
          next_s.state = ocd_pkg::OCD_RUN;
        end
      end
      ocd_pkg::OCD_RUN: begin
        next_s.total = s.total + 8'h1;
        if (s.sub > 4'h1) begin
          next_s.sub = s.sub - 4'h1;
        end else begin
          l = s.left;
          case (s.cyc)
            ocd_pkg::OCD_CYC_FETCH:    l.fetch = l.fetch - 4'h1;
            ocd_pkg::OCD_CYC_BRADDR:   l.braddr = l.braddr - 4'h1;
            ocd_pkg::OCD_CYC_STACK:    l.stack = l.stack - 4'h1;
            ocd_pkg::OCD_CYC_BYTE:     l.byte_acc = l.byte_acc - 4'h1;
            ocd_pkg::OCD_CYC_WORD:     l.word_acc = l.word_acc - 4'h1;
            default:                   l.internal = l.internal - 4'h1;
          endcase
          next_s.left = l;
          // Read precedes write for read-modify-write bit ops
          next_s.write_phase = s.dec.mem_write && s.cyc == ocd_pkg::OCD_CYC_BYTE;
          more = pick(l, c);
          if (more) begin
            n = cyc_states(c, peri_i, peri_slow_i);
            next_s.cyc = c;
            next_s.sub = n;
            next_s.cyc_strobe = 1'b1;
          end else begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.state = ocd_pkg::OCD_DONE;
          end
        end
      end
      ocd_pkg::OCD_DONE: begin
        next_s.write_phase = 1'b0;
        next_s.state = ocd_pkg::OCD_IDLE;
      end
      default: next_s.state = ocd_pkg::OCD_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_q2) begin
    if (!rst_q2) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    busy_o       = s.busy;
    done_o       = s.done;
    cyc_o        = s.cyc;
    cyc_strobe_o = s.cyc_strobe;
    write_o      = s.write_phase;
    op_o         = s.dec.op;
    variant_o    = s.dec.variant;
    cond_o       = s.dec.cond;
    states_o     = s.total;
  end
endmodule
`default_nettype wire

/* File: rtl/ocd_decode.sv */
// First-byte opcode decoder giving operation class and cycle counts
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defs.svh"
module ocd_decode (
  input  wire logic [15:0]      word_i, // First instruction word
  output ocd_pkg::ocd_dec_t     dec_o   // Decoded class and counts
);
  logic [7:0] first;
  logic       split;
  assign first = word_i[`OCD_FIRST_HI:`OCD_FIRST_LO];
  assign split = word_i[`OCD_SPLIT_BIT];

  always_comb begin
    dec_o         = '0;
    dec_o.op      = ocd_pkg::OCD_OP_OTHER;
    dec_o.variant = split;
    dec_o.counts.fetch = 4'h1;
    if (first[7:4] == `OCD_BRANCH_NIBBLE) begin
      dec_o.op           = ocd_pkg::OCD_OP_BRANCH;
      dec_o.cond         = first[3:0];
      dec_o.counts.fetch = 4'h2;
    end else if (first[7:4] == 4'h6 && first[3] == 1'b1) begin
      // Data moves; stack push and pop share these codes
      dec_o.op = ocd_pkg::OCD_OP_DATA_MOVE;
      dec_o.counts.byte_acc = 4'h1;
      if (first == 8'h6d) begin
        dec_o.counts.internal = 4'h2;
      end
      if (first == 8'h6e || first == 8'h6f) begin
        dec_o.counts.fetch = 4'h2;
      end
    end else if (first[7:4] == 4'h7 && first[3] == 1'b0) begin
      // Whole lower half of this row works on a general register
      dec_o.op = ocd_pkg::OCD_OP_BIT_REG;
    end else if (first == 8'h7d || first == 8'h7f) begin
      // Memory bit op: bits 7..4 select read-modify-write or read only
      dec_o.counts.fetch = 4'h2;
      if (word_i[15:8] == 8'h7d && word_i[7:4] <= 4'h2 || word_i[7:4] == 4'h6
          || word_i[7:4] == 4'h7 && !split) begin
        dec_o.op = ocd_pkg::OCD_OP_BIT_WRITE;
        dec_o.mem_write = 1'b1;
        dec_o.counts.byte_acc = 4'h2;
      end else begin
        dec_o.op = ocd_pkg::OCD_OP_BIT_READ;
        dec_o.counts.byte_acc = 4'h1;
      end
    end else if (first == 8'h7c || first == 8'h7e) begin
      dec_o.op = ocd_pkg::OCD_OP_BIT_READ;
      dec_o.counts.fetch = 4'h2;
      dec_o.counts.byte_acc = 4'h1;
    end else if (first == 8'h5d || first == 8'h5e || first == 8'h5f) begin
      dec_o.op = ocd_pkg::OCD_OP_SUB_JUMP;
      dec_o.counts.fetch = 4'h2;
      dec_o.counts.stack = 4'h1;
      if (first == 8'h5e) dec_o.counts.internal = 4'h2;
      if (first == 8'h5f) dec_o.counts.braddr = 4'h1;
    end else if (first == 8'h50 || first == 8'h51) begin
      dec_o.op = ocd_pkg::OCD_OP_MULDIV;
      dec_o.counts.internal = 4'hc;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ocd_defs.svh */
// Timing and field constants for the opcode decode and cycle timing block
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
`define OCD_FIRST_HI        15
`define OCD_FIRST_LO        8
`define OCD_SPLIT_BIT       7
`define OCD_ST_MEM          4'h2
`define OCD_ST_PERI_FAST    4'h2
`define OCD_ST_PERI_SLOW    4'h3
`define OCD_ST_INTERNAL     4'h1
`define OCD_BRANCH_NIBBLE   4'h4
`endif

/* File: rtl/ocd_pkg.sv */
// Types shared by the opcode decode and cycle timing block
package ocd_pkg;
  typedef enum logic [3:0] {
    OCD_OP_OTHER,
    OCD_OP_BRANCH,
    OCD_OP_DATA_MOVE,
    OCD_OP_BIT_WRITE,
    OCD_OP_BIT_READ,
    OCD_OP_BIT_REG,
    OCD_OP_SUB_JUMP,
    OCD_OP_MULDIV
  } ocd_op_t;

  typedef enum logic [2:0] {
    OCD_CYC_FETCH,
    OCD_CYC_BRADDR,
    OCD_CYC_STACK,
    OCD_CYC_BYTE,
    OCD_CYC_WORD,
    OCD_CYC_INTERNAL
  } ocd_cyc_t;

  typedef struct packed {
    logic [3:0] fetch;
    logic [3:0] braddr;
    logic [3:0] stack;
    logic [3:0] byte_acc;
    logic [3:0] word_acc;
    logic [3:0] internal;
  } ocd_counts_t;

  typedef struct packed {
    ocd_op_t     op;
    logic        variant;
    logic        mem_write;
    logic [3:0]  cond;
    ocd_counts_t counts;
  } ocd_dec_t;

  typedef enum logic [1:0] {
    OCD_IDLE,
    OCD_RUN,
    OCD_DONE
  } ocd_state_t;

  typedef struct packed {
    ocd_state_t  state;
    ocd_dec_t    dec;
    ocd_counts_t left;
    ocd_cyc_t    cyc;
    logic [3:0]  sub;
    logic [7:0]  total;
    logic        busy;
    logic        done;
    logic        cyc_strobe;
    logic        write_phase;
  } ocd_state_all_t;
endpackage

/* File: verification/ocd_core_bench.sv */
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module ocd_core_bench;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [15:0] word_i = 16'h0000;
  logic        start_i = 1'b0;
  logic        sel = 1'b0;
  logic        slow = 1'b0;
  logic        peri_i, peri_slow_i, busy_o, done_o, write_o, variant_o, wr_seen;
  logic [3:0]  op_o, cond_o;
  logic [7:0]  states_o;
  int          n_mismatch = 0;
  int          check_count = 0;
  always #25 mclk_i = ~mclk_i;
  ocd_core ocd_core_i (.mclk_i, .rstn_i, .word_i, .start_i, .peri_i, .peri_slow_i, .busy_o,
    .done_o, .cyc_o(), .cyc_strobe_o(), .write_o, .op_o, .variant_o, .cond_o, .states_o);
  ocd_periph_model ocd_periph_model_i (.mclk_i, .sel_i(sel), .slow_i(slow), .peri_o(peri_i),
    .slow_o(peri_slow_i));
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // One instruction, returns in its done cycle
  task automatic run(input logic [15:0] w, input logic p, input logic s);
    int i;
    @(negedge mclk_i);
    sel = p;
    slow = s;
    word_i = w;
    repeat (2) @(negedge mclk_i);
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    wr_seen = 1'b0;
    for (i = 0; i < 60 && done_o !== 1'b1; i++) begin
      wr_seen |= (write_o === 1'b1);
      @(negedge mclk_i);
    end
    if (i == 60) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic t_branch();
    for (int c = 0; c < 16; c++) begin
      run({4'h4, c[3:0], 8'h00}, c[0], 1'b1);
      check(states_o === 8'h04 && cond_o === c[3:0], "branch total or condition");
      check(op_o === ocd_pkg::OCD_OP_BRANCH, "branch class");
    end
  endtask
  task automatic t_bit_reg();
    for (int b = 0; b < 8; b++) begin
      run({4'h7, b[3:0], 8'h10}, 1'b1, 1'b1);
      check(states_o === 8'h02 && op_o === ocd_pkg::OCD_OP_BIT_REG
        && !wr_seen, "reg bit");
    end
  endtask
  task automatic t_bit_mem();
    run(16'h7d00, 1'b0, 1'b0);
    check(states_o === 8'h08 && op_o === ocd_pkg::OCD_OP_BIT_WRITE
      && wr_seen, "bit write");
    run(16'h7d00, 1'b1, 1'b1);
    check(states_o === 8'h0a && wr_seen, "slow peripheral bit write");
    run(16'h7c00, 1'b0, 1'b0);
    check(states_o === 8'h06 && op_o === ocd_pkg::OCD_OP_BIT_READ
      && !wr_seen, "bit read");
    run(16'h7c00, 1'b1, 1'b1);
    check(states_o === 8'h07, "slow peripheral bit read");
    run(16'h7c00, 1'b1, 1'b0);
    check(states_o === 8'h06, "fast peripheral bit read");
  endtask
  task automatic t_push_pop();
    run(16'h6df0, 1'b0, 1'b0);
    check(op_o === ocd_pkg::OCD_OP_DATA_MOVE && variant_o === 1'b1, "push decode");
    check(states_o === 8'h06, "push total");
    run(16'h6d70, 1'b0, 1'b0);
    check(op_o === ocd_pkg::OCD_OP_DATA_MOVE && variant_o === 1'b0, "pop decode");
  endtask
  // Subroutine jumps and multiply: stack, branch-address and internal cycles
  task automatic t_jump_muldiv();
    run(16'h5d00, 1'b0, 1'b0);
    check(states_o === 8'h06
      && op_o === ocd_pkg::OCD_OP_SUB_JUMP, "register jump total");
    run(16'h5f00, 1'b0, 1'b0);
    check(states_o === 8'h08, "indirect jump total");
    run(16'h5e00, 1'b0, 1'b0);
    check(states_o === 8'h08, "absolute jump total");
    run(16'h5000, 1'b1, 1'b1);
    check(states_o === 8'h0e, "multiply total");
  endtask
  task automatic t_refuse();
    int n;
    logic [7:0] st;
    n = 0;
    st = 8'h00;
    @(negedge mclk_i);
    word_i = 16'h4000;
    start_i = 1'b1;
    @(negedge mclk_i);
    word_i = 16'h7000;
    repeat (2) @(negedge mclk_i);
    start_i = 1'b0;
    repeat (12) begin
      @(negedge mclk_i);
      if (done_o === 1'b1) begin
        n++;
        st = states_o;
      end
    end
    check(n == 1 && st === 8'h04, "start during busy was taken");
  endtask
  initial begin
    repeat (12) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_branch();
    t_bit_reg();
    t_bit_mem();
    t_push_pop();
    t_jump_muldiv();
    t_refuse();
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: verification/ocd_core_monitor.sv */
// Assertion checker for the instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module ocd_core_monitor (
  input wire logic        mclk_i,       // Clock
  input wire logic        rstn_i,       // Reset, active low
  input wire logic [15:0] word_i,       // First word
  input wire logic        busy_o,       // Executing
  input wire logic        done_o,       // Finished pulse
  input wire logic [2:0]  cyc_o,        // Cycle type
  input wire logic        cyc_strobe_o, // Cycle start
  input wire logic [3:0]  op_o,         // Class
  input wire logic        variant_o,    // Split bit
  input wire logic [7:0]  states_o      // State count
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  AST_DONE_END: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("done without a preceding busy cycle");
  AST_BOUND: assert property ($rose(busy_o) |-> ##[1:40] done_o)
    else $error("instruction did not finish");
  AST_FIRST_FETCH: assert property ($rose(busy_o) |-> cyc_strobe_o && cyc_o == 3'h0)
    else $error("first cycle is not a fetch");
  AST_DECODE: assert property ($rose(busy_o) |-> variant_o == $past(word_i[7])
    && ((op_o == ocd_pkg::OCD_OP_BRANCH) == ($past(word_i[15:12]) == 4'h4)))
    else $error("class or split bit wrong");
  AST_BRANCH: assert property (done_o && op_o == ocd_pkg::OCD_OP_BRANCH
    |-> states_o == 8'h04)
    else $error("branch state total wrong");
  AST_BIT_REG: assert property (done_o && op_o == ocd_pkg::OCD_OP_BIT_REG
    |-> states_o == 8'h02)
    else $error("register bit op total wrong");
  AST_BIT_WR: assert property (done_o && op_o == ocd_pkg::OCD_OP_BIT_WRITE
    |-> states_o inside {8'h08, 8'h0a})
    else $error("memory bit write total wrong");
  AST_BIT_RD: assert property (done_o && op_o == ocd_pkg::OCD_OP_BIT_READ
    |-> states_o inside {8'h06, 8'h07})
    else $error("memory bit read total wrong");
endmodule
bind ocd_core ocd_core_monitor ocd_core_monitor_i (.mclk_i, .rstn_i, .word_i, .busy_o, .done_o,
  .cyc_o, .cyc_strobe_o, .op_o, .variant_o, .states_o);
`default_nettype wire

/* File: verification/ocd_periph_model.sv */
// Memory and peripheral target model on the internal bus
`timescale 1ns/1ps
`default_nettype none
module ocd_periph_model (
  input  wire logic mclk_i, // Clock
  input  wire logic sel_i,  // Peripheral addressed
  input  wire logic slow_i, // Slow module addressed
  output logic      peri_o, // Access targets peripheral
  output logic      slow_o  // Three-state module
);
  always_ff @(posedge mclk_i) begin
    peri_o <= sel_i;
    slow_o <= sel_i & slow_i;
  end
endmodule
`default_nettype wire
